// file: design/flash_host_ctrl.sv
// Purpose: Host controller issuing flash command sequences and polls.
// Assumes: Flash pins driven directly; data pins split in, out, enable.
// Notes: Completion found by toggle bit alone; poll bit not checked.
`timescale 1ns/1ps

// Summary of operation
// - Write strobe held high throughout every read
// - Program: unlock pair, A0H, then target byte
// - Sector erase: unlock, 80H, unlock, 30H
// - Chip erase: same prefix, final 10H at 5555H
// - Caller erases a sector before reprogramming
// - Completion found by toggle bit only
module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter int PROG_TIMEOUT = PROG_TIMEOUT_CYC,
    parameter int SECT_TIMEOUT = SECT_TIMEOUT_CYC,
    parameter int CHIP_TIMEOUT = CHIP_TIMEOUT_CYC
)(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire flash_host_pkg::op_t cmd_op,
    input wire logic [flash_host_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [flash_host_pkg::DATA_W-1:0] cmd_data,
    output logic rsp_valid,
    output logic [flash_host_pkg::DATA_W-1:0] rsp_data,
    output logic rsp_timeout,
    output logic chip_sel_b,
    output logic out_gate_b,
    output logic wr_strobe_b,
    output logic [flash_host_pkg::ADDR_W-1:0] addr_pin,
    output logic [flash_host_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic [flash_host_pkg::DATA_W-1:0] data_in
);
    import flash_host_pkg::*;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_ISSUE = 5'b00010,
        S_POLL_A = 5'b00100,
        S_POLL_B = 5'b01000,
        S_RESP = 5'b10000
    } host_state_t;

    flash_bus_if bus ();

    host_state_t state_ff, nxt_state;
    op_t op_ff, nxt_op;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [DATA_W-1:0] data_ff, nxt_data;
    logic [2:0] step_ff, nxt_step;
    logic [DATA_W-1:0] prev_ff, nxt_prev;
    logic [TMO_W-1:0] tmo_ff, nxt_tmo;
    logic tout_ff, nxt_tout;
    logic [DATA_W-1:0] rsp_ff, nxt_rsp;
    logic [2:0] last_step;
    logic [ADDR_W-1:0] seq_addr;
    logic [DATA_W-1:0] seq_data;
    logic seq_wr;
    logic busy_op;

    // Cycle list for each operation, one entry per bus cycle
    always_comb begin
        seq_wr = 1'b1;
        seq_addr = UNLOCK_ADDR1;
        seq_data = UNLOCK_DATA1;
        last_step = 3'd0;
        case (op_ff)
            OP_READ: begin
                seq_wr = 1'b0;
                seq_addr = addr_ff;
            end
            OP_ABORT: begin
                seq_data = CMD_RESET;
            end
            OP_PROGRAM, OP_READ_ID: begin
                last_step = (op_ff == OP_PROGRAM) ? 3'd3 : 3'd4;
                if (step_ff == 3'd1) begin
                    seq_addr = UNLOCK_ADDR2;
                    seq_data = UNLOCK_DATA2;
                end else if (step_ff == 3'd2) begin
                    // Third cycle: program or autoselect code
                    seq_data = (op_ff == OP_PROGRAM) ? CMD_PROGRAM
                                                      : CMD_AUTOSELECT;
                end else if (step_ff == 3'd3 && op_ff == OP_PROGRAM) begin
                    seq_addr = addr_ff;
                    // Only clears bits; caller erases first
                    seq_data = data_ff;
                end else if (step_ff == 3'd3) begin
                    seq_wr = 1'b0;
                    seq_addr = addr_ff[0] ? ID_VARIANT_OFS
                                          : ID_MAKER_OFS;
                end else if (step_ff == 3'd4) begin
                    seq_data = CMD_RESET;
                end
            end
            default: begin
                last_step = 3'd5;
                if (step_ff == 3'd1 || step_ff == 3'd4) begin
                    seq_addr = UNLOCK_ADDR2;
                    seq_data = UNLOCK_DATA2;
                end else if (step_ff == 3'd2) begin
                    seq_data = CMD_ERASE_SETUP;
                end else if (step_ff == 3'd5 && op_ff == OP_SECTOR_ERASE) begin
                    seq_addr = addr_ff;
                    seq_data = CMD_SECTOR_ERASE;
                end else if (step_ff == 3'd5) begin
                    seq_data = CMD_CHIP_ERASE;
                end
            end
        endcase
    end

    assign busy_op = (op_ff == OP_PROGRAM) || (op_ff == OP_SECTOR_ERASE)
                     || (op_ff == OP_CHIP_ERASE);
    assign bus.req = (state_ff == S_ISSUE)
                     || (state_ff == S_POLL_A) || (state_ff == S_POLL_B);
    assign bus.wr = (state_ff == S_ISSUE) ? seq_wr : 1'b0;
    assign bus.addr = (state_ff == S_ISSUE) ? seq_addr : addr_ff;
    assign bus.wdata = seq_data;

    always_comb begin
        nxt_state = state_ff;
        nxt_op = op_ff;
        nxt_addr = addr_ff;
        nxt_data = data_ff;
        nxt_step = step_ff;
        nxt_prev = prev_ff;
        nxt_tmo = tmo_ff;
        nxt_tout = tout_ff;
        nxt_rsp = rsp_ff;
        case (state_ff)
            S_IDLE: begin
                // New command only once the previous one has ended
                if (cmd_valid) begin
                    nxt_op = cmd_op;
                    nxt_addr = cmd_addr;
                    nxt_data = cmd_data;
                    nxt_step = 3'd0;
                    nxt_tout = 1'b0;
                    nxt_state = S_ISSUE;
                end
            end
            S_ISSUE: begin
                if (bus.done) begin
                    if (!seq_wr) begin
                        nxt_rsp = bus.rdata;
                    end
                    if (step_ff != last_step) begin
                        nxt_step = step_ff + 3'd1;
                    end else if (busy_op) begin
                        if (op_ff == OP_PROGRAM) begin
                            nxt_tmo = TMO_W'(PROG_TIMEOUT);
                        end else if (op_ff == OP_SECTOR_ERASE) begin
                            nxt_tmo = TMO_W'(SECT_TIMEOUT);
                        end else begin
                            nxt_tmo = TMO_W'(CHIP_TIMEOUT);
                        end
                        nxt_state = S_POLL_A;
                    end else begin
                        nxt_state = S_RESP;
                    end
                end
            end
            S_POLL_A, S_POLL_B: begin
                if (tmo_ff != '0) begin
                    nxt_tmo = tmo_ff - TMO_W'(1);
                end
                if (bus.done) begin
                    nxt_prev = bus.rdata;
                    nxt_rsp = bus.rdata;
                    nxt_state = S_POLL_B;
                    // Stable bit six on two reads means done
                    if (state_ff == S_POLL_B && (bus.rdata[TOGGLE_BIT]
                            == prev_ff[TOGGLE_BIT])) begin
                        nxt_state = S_RESP;
                    end else if (tmo_ff == '0) begin
                        // Bounded wait: flash overran its worst case
                        nxt_tout = 1'b1;
                        nxt_state = S_RESP;
                    end
                end
            end
            S_RESP: begin
                nxt_state = S_IDLE;
            end
            default: nxt_state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= S_IDLE;
            op_ff <= OP_READ;
            addr_ff <= '0;
            data_ff <= '0;
            step_ff <= '0;
            prev_ff <= '0;
            tmo_ff <= '0;
            tout_ff <= 1'b0;
            rsp_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            op_ff <= nxt_op;
            addr_ff <= nxt_addr;
            data_ff <= nxt_data;
            step_ff <= nxt_step;
            prev_ff <= nxt_prev;
            tmo_ff <= nxt_tmo;
            tout_ff <= nxt_tout;
            rsp_ff <= nxt_rsp;
        end
    end

    assign cmd_ready = (state_ff == S_IDLE);
    assign rsp_valid = (state_ff == S_RESP);
    assign rsp_data = rsp_ff;
    assign rsp_timeout = tout_ff;

    flash_cycle_engine u_engine (
        .clk(clk),
        .rst_b(rst_b),
        .bus(bus.eng),
        .chip_sel_b(chip_sel_b),
        .out_gate_b(out_gate_b),
        .wr_strobe_b(wr_strobe_b),
        .addr_pin(addr_pin),
        .data_out(data_out),
        .data_oe(data_oe),
        .data_in(data_in)
    );
endmodule // flash_host_ctrl

// file: design/flash_host_pkg.sv
// Purpose: Constants shared by the parallel flash host controller.
// Assumes: 40 MHz clock, byte-wide flash with 17 address bits.
// Notes: Command codes and unlock addresses of the flash command set.
package flash_host_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SECTOR_COUNT = 256;
    localparam int SECTOR_BYTES = 512;
    localparam int BOOT_SECTORS = 16;
    localparam logic [ADDR_W-1:0] BOOT_TOP_START = 17'h1E000;
    localparam logic [ADDR_W-1:0] BOOT_TOP_END = 17'h1FFFF;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 17'h05555;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 17'h02AAA;
    localparam logic [ADDR_W-1:0] ID_MAKER_OFS = 17'h00000;
    localparam logic [ADDR_W-1:0] ID_VARIANT_OFS = 17'h00001;
    localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 8'hAA;
    localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 8'h55;
    localparam logic [DATA_W-1:0] CMD_PROGRAM = 8'hA0;
    localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [DATA_W-1:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [DATA_W-1:0] CMD_RESET = 8'hF0;
    localparam logic [DATA_W-1:0] CMD_AUTOSELECT = 8'h90;
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    // Bus phase times in ns, slowest speed grade
    localparam int T_SETUP_NS = 30;
    localparam int T_PULSE_NS = 45;
    localparam int T_RECOVER_NS = 38;
    localparam int T_ACCESS_NS = 90;
    localparam int T_FLOAT_NS = 30;
    // Least times round up
    localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYC = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC =
        (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC =
        (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLOAT_CYC = (T_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    // Busy timeouts: program 20 us, sector erase 10 ms, chip erase 500 ms
    localparam int T_PROG_US = 20;
    localparam int T_SECT_MS = 10;
    localparam int T_CHIP_MS = 500;
    localparam int PROG_TIMEOUT_CYC = T_PROG_US * 1000 / CLK_PERIOD_NS;
    localparam int SECT_TIMEOUT_CYC = T_SECT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int CHIP_TIMEOUT_CYC = T_CHIP_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TMO_W = 26;

    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_PROGRAM = 3'h1,
        OP_SECTOR_ERASE = 3'h2,
        OP_CHIP_ERASE = 3'h3,
        OP_ABORT = 3'h4,
        OP_READ_ID = 3'h5
    } op_t;
endpackage

// file: design/flash_bus_if.sv
// Purpose: Carrier between the sequencer and its bus cycle engine.
// Assumes: One clock domain.
// Notes: The engine does one write or read cycle per request.
`timescale 1ns/1ps
interface flash_bus_if;
    import flash_host_pkg::*;
    logic req;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic done;
    logic [DATA_W-1:0] rdata;
    modport seq (output req, output wr, output addr, output wdata,
                 input done, input rdata);
    modport eng (input req, input wr, input addr, input wdata,
                 output done, output rdata);
endinterface

// file: design/flash_cycle_engine.sv
// Purpose: Drives one flash bus cycle, write or read, on the pins.
// Assumes: Data pins come back through two flip-flops.
// Notes: Write strobe controlled cycles; chip select framed around it.
`timescale 1ns/1ps
module flash_cycle_engine
    import flash_host_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    flash_bus_if.eng bus,
    output logic chip_sel_b,
    output logic out_gate_b,
    output logic wr_strobe_b,
    output logic [flash_host_pkg::ADDR_W-1:0] addr_pin,
    output logic [flash_host_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic [flash_host_pkg::DATA_W-1:0] data_in
);
    import flash_host_pkg::*;

    typedef enum logic [4:0] {
        E_IDLE = 5'b00001,
        E_SETUP = 5'b00010,
        E_ACT = 5'b00100,
        E_HOLD = 5'b01000,
        E_DONE = 5'b10000
    } eng_state_t;

    eng_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic wr_ff, nxt_wr;
    logic cs_ff, nxt_cs, oe_ff, nxt_oe, we_ff, nxt_we, doe_ff, nxt_doe;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [DATA_W-1:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
    logic [DATA_W-1:0] sync1_ff, sync2_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_wr = wr_ff;
        nxt_cs = cs_ff;
        nxt_oe = oe_ff;
        nxt_we = we_ff;
        nxt_doe = doe_ff;
        nxt_addr = addr_ff;
        nxt_wd = wd_ff;
        nxt_rd = rd_ff;
        case (state_ff)
            E_IDLE: begin
                if (bus.req) begin
                    nxt_wr = bus.wr;
                    nxt_addr = bus.addr;
                    nxt_wd = bus.wdata;
                    nxt_cs = 1'b1;
                    // Strobe stays high for the whole read
                    nxt_we = 1'b0;
                    nxt_doe = bus.wr;
                    nxt_cnt = CNT_W'(SETUP_CYC);
                    nxt_state = E_SETUP;
                end
            end
            E_SETUP: begin
                if (cnt_ff > CNT_W'(1)) begin
                    nxt_cnt = cnt_ff - CNT_W'(1);
                end else begin
                    // Address captured at strobe fall, after select
                    nxt_we = wr_ff;
                    nxt_oe = !wr_ff;
                    nxt_cnt = wr_ff ? CNT_W'(PULSE_CYC)
                                    : CNT_W'(ACCESS_CYC + 2);
                    nxt_state = E_ACT;
                end
            end
            E_ACT: begin
                if (cnt_ff > CNT_W'(1)) begin
                    nxt_cnt = cnt_ff - CNT_W'(1);
                end else begin
                    // Data taken at the strobe rise, bus still driven
                    nxt_we = 1'b0;
                    nxt_oe = 1'b0;
                    if (!wr_ff) begin
                        nxt_rd = sync2_ff;
                    end
                    nxt_cnt = CNT_W'(wr_ff ? RECOVER_CYC : FLOAT_CYC);
                    nxt_state = E_HOLD;
                end
            end
            E_HOLD: begin
                nxt_cs = 1'b0;
                nxt_doe = 1'b0;
                if (cnt_ff > CNT_W'(1)) begin
                    nxt_cnt = cnt_ff - CNT_W'(1);
                end else begin
                    nxt_state = E_DONE;
                end
            end
            E_DONE: begin
                nxt_state = E_IDLE;
            end
            default: nxt_state = E_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= E_IDLE;
            cnt_ff <= '0;
            wr_ff <= 1'b0;
            cs_ff <= 1'b0;
            oe_ff <= 1'b0;
            we_ff <= 1'b0;
            doe_ff <= 1'b0;
            addr_ff <= '0;
            wd_ff <= '0;
            rd_ff <= '0;
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            wr_ff <= nxt_wr;
            cs_ff <= nxt_cs;
            oe_ff <= nxt_oe;
            we_ff <= nxt_we;
            doe_ff <= nxt_doe;
            addr_ff <= nxt_addr;
            wd_ff <= nxt_wd;
            rd_ff <= nxt_rd;
            sync1_ff <= data_in;
            sync2_ff <= sync1_ff;
        end
    end

    assign chip_sel_b = !cs_ff;
    assign out_gate_b = !oe_ff;
    assign wr_strobe_b = !we_ff;
    assign addr_pin = addr_ff;
    assign data_out = wd_ff;
    assign data_oe = doe_ff;
    assign bus.done = (state_ff == E_DONE);
    assign bus.rdata = rd_ff;
endmodule // flash_cycle_engine

// file: dv/flash_pins_monitor.sv
// Purpose: Pin protocol checks for the parallel flash host controller.
// Assumes: One clock; all flash strobes registered in the controller.
// Notes: Bound to every instance of the controller.
`timescale 1ns/1ps
module flash_pins_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic chip_sel_b,
    input wire logic out_gate_b,
    input wire logic wr_strobe_b,
    input wire logic [flash_host_pkg::ADDR_W-1:0] addr_pin,
    input wire logic [flash_host_pkg::DATA_W-1:0] data_out,
    input wire logic data_oe
);
    import flash_host_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_strobe_low;
        !wr_strobe_b [*2];
    endsequence
    sequence s_gate_low;
        (!out_gate_b && !chip_sel_b && wr_strobe_b) [*4];
    endsequence
    property p_gate_in_sel;
        !out_gate_b |-> !chip_sel_b;
    endproperty
    a_gate_in_sel: assert property (p_gate_in_sel)
        else $error("output gate low without chip select");
    property p_read_frame;
        $fell(out_gate_b) |-> s_gate_low;
    endproperty
    a_read_frame: assert property (p_read_frame)
        else $error("read frame too short or strobe low in read");
    property p_no_contention;
        data_oe |-> out_gate_b;
    endproperty
    a_no_contention: assert property (p_no_contention)
        else $error("host drives data while gate is low");
    property p_idle_at_rsp;
        rsp_valid |-> chip_sel_b && out_gate_b && wr_strobe_b && !data_oe;
    endproperty
    a_idle_at_rsp: assert property (p_idle_at_rsp)
        else $error("bus not released at response");
    property p_addr_latch;
        $fell(wr_strobe_b) |-> !chip_sel_b && data_oe && $stable(addr_pin);
    endproperty
    a_addr_latch: assert property (p_addr_latch)
        else $error("address not settled at strobe fall");
    property p_strobe_pulse;
        $fell(wr_strobe_b) |-> s_strobe_low ##1 (wr_strobe_b && !chip_sel_b);
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse)
        else $error("write strobe pulse malformed");
    property p_data_hold;
        $rose(wr_strobe_b) |->
            data_oe && $stable(data_out) && $stable(addr_pin);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("data moved at strobe rise");
    property p_take_once;
        cmd_valid && cmd_ready |=> !cmd_ready;
    endproperty
    a_take_once: assert property (p_take_once)
        else $error("ready stayed high after a command");
    property p_rsp_pulse;
        rsp_valid |=> !rsp_valid && cmd_ready;
    endproperty
    a_rsp_pulse: assert property (p_rsp_pulse)
        else $error("response not one cycle or ready late");
    property p_standby_idle;
        cmd_ready |-> chip_sel_b;
    endproperty
    a_standby_idle: assert property (p_standby_idle)
        else $error("select low while idle");
endmodule // flash_pins_monitor

bind flash_host_ctrl flash_pins_monitor mon_u (
    .clk(clk),
    .rst_b(rst_b),
    .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid),
    .chip_sel_b(chip_sel_b),
    .out_gate_b(out_gate_b),
    .wr_strobe_b(wr_strobe_b),
    .addr_pin(addr_pin),
    .data_out(data_out),
    .data_oe(data_oe)
);

// file: dv/flash_device_model.sv
// Purpose: Behavioural byte-wide flash seen from its pins.
// Assumes: Busy times are shortened so the run stays brief.
// Notes: Boot lock is not modelled; floated pins show inverted data.
`timescale 1ns/1ps
module flash_device_model
    import flash_host_pkg::*;
#(
    parameter int PROG_NS = 2000,
    parameter int SECT_NS = 5000,
    parameter int CHIP_NS = 12000,
    // Identity codes are arbitrary
    parameter logic [7:0] MAKER_CODE = 8'h5A,
    parameter logic [7:0] VARIANT_CODE = 8'hC3
)(
    input wire logic chip_sel_b,
    input wire logic out_gate_b,
    input wire logic wr_strobe_b,
    input wire logic [flash_host_pkg::ADDR_W-1:0] addr_pin,
    input wire logic [flash_host_pkg::DATA_W-1:0] data_out,
    input wire logic data_oe,
    output logic [flash_host_pkg::DATA_W-1:0] data_in
);
    logic [DATA_W-1:0] mem [0:SECTOR_COUNT*SECTOR_BYTES-1];
    logic [ADDR_W-1:0] lat_a = '0;
    logic [DATA_W-1:0] tgt = 8'hFF;
    logic [DATA_W-1:0] float_v = 8'h00;
    logic [DATA_W-1:0] d;
    logic busy = 1'b0;
    logic tog = 1'b0;
    logic id_mode = 1'b0;
    int step = 0;
    wire rd_on = !chip_sel_b && !out_gate_b;
    wire wr_on = !chip_sel_b && !wr_strobe_b;
    initial foreach (mem[i]) mem[i] = ERASED_BYTE;
    task automatic go_busy(input int ns, input logic [7:0] v);
        tgt = v;
        busy = 1'b1;
        fork
            begin
                #(ns);
                busy = 1'b0;
            end
        join_none
    endtask
    assign data_in = !rd_on ? float_v : id_mode ?
        (addr_pin[0] ? VARIANT_CODE : MAKER_CODE) :
        busy ? {~tgt[7], tog, tgt[5:0]} : mem[addr_pin];
    always @(data_in) if (rd_on) float_v = ~data_in;
    always @(negedge rd_on) if (busy) tog = ~tog;
    always @(posedge wr_on) lat_a = addr_pin;
    always @(negedge wr_on) begin
        d = data_out;
        if (busy) begin
            step = 0;
        end else if (d == CMD_RESET && step != 3) begin
            step = 0;
            id_mode = 1'b0;
        end else begin
            case (step)
                0, 4: step = (lat_a == UNLOCK_ADDR1 && d == UNLOCK_DATA1) ?
                    step + 1 : 0;
                1, 5: step = (lat_a == UNLOCK_ADDR2 && d == UNLOCK_DATA2) ?
                    step + 1 : 0;
                2: begin
                    id_mode = lat_a == UNLOCK_ADDR1 && d == CMD_AUTOSELECT;
                    step = lat_a != UNLOCK_ADDR1 ? 0 : d == CMD_PROGRAM ? 3 :
                        d == CMD_ERASE_SETUP ? 4 : 0;
                end
                3: begin
                    mem[lat_a] = mem[lat_a] & d;
                    go_busy(PROG_NS, d);
                    step = 0;
                end
                6: begin
                    if (d == CMD_SECTOR_ERASE) begin
                        for (int i = 0; i < SECTOR_BYTES; i++)
                            mem[{lat_a[16:9], 9'h000} + i] = ERASED_BYTE;
                        go_busy(SECT_NS, ERASED_BYTE);
                    end else if (d == CMD_CHIP_ERASE &&
                                 lat_a == UNLOCK_ADDR1) begin
                        foreach (mem[i]) mem[i] = ERASED_BYTE;
                        go_busy(CHIP_NS, ERASED_BYTE);
                    end
                    step = 0;
                end
                default: step = 0;
            endcase
        end
    end
endmodule // flash_device_model

// file: dv/testbench.sv
// Purpose: Self-checking bench for the parallel flash host controller.
// Assumes: Device model busy times well inside the shortened timeouts.
// Notes: A shadow array predicts program results and sector test reads; other array bytes are expected erased; identity bytes are checked against the codes.
`timescale 1ns/1ps
module testbench;
    import flash_host_pkg::*;
    // Identity codes are arbitrary
    localparam logic [7:0] MAKER_CODE = 8'h5A;
    localparam logic [7:0] VARIANT_CODE = 8'hC3;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_valid = 1'b0;
    op_t cmd_op = OP_READ;
    logic [ADDR_W-1:0] cmd_addr = '0;
    logic [DATA_W-1:0] cmd_data = '0;
    logic cmd_ready, rsp_valid, rsp_timeout;
    logic chip_sel_b, out_gate_b, wr_strobe_b, data_oe;
    logic [DATA_W-1:0] rsp_data, data_out, data_in;
    logic [ADDR_W-1:0] addr_pin;
    logic [7:0] shadow [0:SECTOR_COUNT*SECTOR_BYTES-1];
    logic [31:0] seed = 32'h0000_4992;
    int mismatches = 0;
    int compares = 0;
    always #(CLK_PERIOD_NS / 2.0) clk = ~clk;
    flash_host_ctrl #(.PROG_TIMEOUT(200), .SECT_TIMEOUT(400),
        .CHIP_TIMEOUT(1000)) dut_u (.clk(clk), .rst_b(rst_b),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_timeout(rsp_timeout),
        .chip_sel_b(chip_sel_b), .out_gate_b(out_gate_b),
        .wr_strobe_b(wr_strobe_b), .addr_pin(addr_pin),
        .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
    flash_device_model #(.MAKER_CODE(MAKER_CODE),
        .VARIANT_CODE(VARIANT_CODE)) dev_u (.chip_sel_b(chip_sel_b),
        .out_gate_b(out_gate_b), .wr_strobe_b(wr_strobe_b),
        .addr_pin(addr_pin), .data_out(data_out), .data_oe(data_oe),
        .data_in(data_in));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Programming can only clear bits
    function automatic logic [7:0] prog_exp(input logic [16:0] a,
                                            input logic [7:0] d);
        shadow[a] = shadow[a] & d;
        return shadow[a];
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // Entered just after a rising edge; a new request may overlap ready low
    task automatic run(input op_t op, input logic [16:0] a,
                       input logic [7:0] d, input logic [7:0] want);
        int n;
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_data <= d;
        @(posedge clk);
        while (cmd_ready !== 1'b1) @(posedge clk);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 4000);
        check({7'h00, rsp_valid}, 8'h01);
        check(rsp_data, want);
        check({7'h00, rsp_timeout}, 8'h00);
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #(CLK_PERIOD_NS * 40000);
        mismatches++;
        wrap_up();
    end
    initial begin
        logic [16:0] base, a;
        logic [31:0] r;
        logic [7:0] secs [3];
        foreach (shadow[i]) shadow[i] = ERASED_BYTE;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check({chip_sel_b, out_gate_b, wr_strobe_b, data_oe, 4'h0},
              8'hE0);
        run(OP_READ, BOOT_TOP_END, 8'h00, ERASED_BYTE);
        $display("test reset_blank done");
        run(OP_READ_ID, ID_MAKER_OFS, 8'h00, MAKER_CODE);
        run(OP_READ_ID, ID_VARIANT_OFS, 8'h00, VARIANT_CODE);
        // Abort reads nothing, so the last id byte stays
        run(OP_ABORT, UNLOCK_ADDR1, 8'h00, VARIANT_CODE);
        run(OP_READ, 17'h00001, 8'h00, ERASED_BYTE);
        $display("test ident_abort done");
        r = rnd();
        secs = '{8'hFF, 8'h00, r[7:0]};
        foreach (secs[k]) begin
            base = {secs[k], 9'h000};
            r = rnd();
            a = base | {8'h00, r[8:0]};
            for (int i = 0; i < SECTOR_BYTES; i++)
                shadow[base + i] = ERASED_BYTE;
            run(OP_SECTOR_ERASE, a, 8'h00, ERASED_BYTE);
            for (int i = 0; i < 6; i++) begin
                r = rnd();
                a = i == 0 ? base : i == 1 ? base + 17'h001FF :
                    base | {8'h00, r[16:8]};
                run(OP_PROGRAM, a, r[7:0],
                    prog_exp(a, r[7:0]));
                run(OP_READ, a, 8'h00, shadow[a]);
            end
            run(OP_PROGRAM, base, 8'hF0, prog_exp(base, 8'hF0));
            a = base ^ 17'h00200;
            run(OP_READ, a, 8'h00, shadow[a]);
            $display("test sector %0d done", k);
        end
        foreach (shadow[i]) shadow[i] = ERASED_BYTE;
        run(OP_CHIP_ERASE, UNLOCK_ADDR1, 8'h00, ERASED_BYTE);
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            run(OP_READ, r[16:0], 8'h00, ERASED_BYTE);
        end
        run(OP_READ, BOOT_TOP_START, 8'h00, ERASED_BYTE);
        $display("test chip_erase done");
        wrap_up();
    end
endmodule // testbench
